// ===== dcl_regs.svh
// drive command logic constants: timing, pin indices, reset values, scaling
`ifndef DCL_REGS_SVH
`define DCL_REGS_SVH
// Contract
// - one input may drive several functions
// - two-wire code: one input runs and stops
// - level sense: run at 1, stop at 0
// - transition sense: start only on edge
// - forward priority: forward beats reverse
// - three-wire: input one stops on opening
// - three-wire: run pulse latched until stop
// - three-wire: rearm only after both released
// - forward fixed: input one, three-wire input two
// - reverse unassigned: forward rotation only
// - two presets: low select picks speed
// - four presets decoded from high, low selects
// - active preset overrides analog reference
// - fault reset rising edge clears fault
// - overcurrent, short, internal faults need power-off
// - ramp switch picks secondary ramp times
// - logic output active sinks to common
// - analog output is fixed-rate pwm
// - current full scale is twice nominal
// - frequency full scale is high speed limit
// - threshold modes assert above threshold
// - reference reached asserts at reference
`define DCL_CLK_HZ          200000000
`define DCL_PWM_HZ          2000
`define DCL_PWM_PERIOD_CYC  (`DCL_CLK_HZ / `DCL_PWM_HZ)
`define DCL_CUR_FULL_PCT    200
`define DCL_FREQ_FULL_PCT   100
`define DCL_PCT_DEN         100
`define DCL_STOP_IDX        2'h0
`define DCL_FWD_IDX_2W      2'h0
`define DCL_FWD_IDX_3W      2'h1
`define DCL_IN_RST          4'h0
`endif

// ===== dcl_pkg.sv
// drive command logic types: control codes, two-wire types, preset and output modes
package dcl_pkg;
  // control type select codes
  typedef enum logic {
    dcl_two_wire_code,
    dcl_three_wire_code
  } dcl_ctrl_t;
  // two-wire behaviour
  typedef enum logic [1:0] {
    dcl_level_sense,
    dcl_transition_sense,
    dcl_forward_priority
  } dcl_two_wire_t;
  // preset speed count
  typedef enum logic [1:0] {
    dcl_preset_none,
    dcl_preset_two,
    dcl_preset_four
  } dcl_preset_t;
  // multi-function output use: analog modes then switch modes
  typedef enum logic [2:0] {
    dcl_ao_current,
    dcl_ao_frequency,
    dcl_lo_freq_thresh,
    dcl_lo_ref_reached,
    dcl_lo_cur_thresh
  } dcl_out_mode_t;
endpackage : dcl_pkg

// ===== dcl_drive_cmd.sv
// drive command logic: input sync, run/stop, presets, fault reset, ramps, multi-function output
`include "dcl_regs.svh"
module dcl_drive_cmd #(
  parameter int          SPD_W          = 16,                    // speed and current width
  parameter int unsigned PWM_PERIOD_CYC = `DCL_PWM_PERIOD_CYC,   // cycles per pwm period
  parameter int          RAMP_W         = 10                     // ramp time width
) (
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire logic [3:0]             logic_in_pin,          // four programmable inputs
  input  wire dcl_pkg::dcl_ctrl_t     control_type_select,
  input  wire dcl_pkg::dcl_two_wire_t two_wire_type,
  input  wire logic                   reverse_assign_en,     // low: no reverse input
  input  wire logic [1:0]             reverse_assign,        // input index for reverse
  input  wire dcl_pkg::dcl_preset_t   preset_mode,
  input  wire logic [1:0]             preset_select_low,     // input index, low select
  input  wire logic [1:0]             preset_select_high,    // input index, high select
  input  wire logic                   fault_reset_en,
  input  wire logic [1:0]             fault_reset_idx,
  input  wire logic                   ramp_switch_en,
  input  wire logic [1:0]             ramp_switch_input,     // input index, ramp switch
  input  wire logic [SPD_W-1:0]       speed_ref,             // analog or pot reference
  input  wire logic [SPD_W-1:0]       low_speed_limit,
  input  wire logic [SPD_W-1:0]       high_speed_limit,
  input  wire logic [SPD_W-1:0]       preset_speed_second,
  input  wire logic [SPD_W-1:0]       preset_speed_third,
  input  wire logic [SPD_W-1:0]       preset_speed_fourth,
  input  wire logic [RAMP_W-1:0]      primary_ramp_up_time,
  input  wire logic [RAMP_W-1:0]      primary_ramp_down_time,
  input  wire logic [RAMP_W-1:0]      second_ramp_up_time,
  input  wire logic [RAMP_W-1:0]      second_ramp_down_time,
  input  wire logic                   fault_detect,          // pulse: new fault seen
  input  wire logic                   fault_power_only,      // with detect: power-off class
  input  wire logic                   fault_cause_present,   // cause still active
  input  wire logic [SPD_W-1:0]       motor_freq,
  input  wire logic [SPD_W-1:0]       motor_current,
  input  wire logic [SPD_W-1:0]       nominal_current,
  input  wire logic [SPD_W-1:0]       freq_threshold,
  input  wire logic [SPD_W-1:0]       current_threshold,
  input  wire dcl_pkg::dcl_out_mode_t out_mode,
  output logic                        run_fwd_q,             // forward run command
  output logic                        run_rev_q,             // reverse run command
  output logic                        motor_enable,          // power stage allowed
  output logic                        ramp_stop_q,           // pulse: ramped stop request
  output logic [SPD_W-1:0]            speed_cmd_q,           // selected speed reference
  output logic                        fault_soft_q,          // resettable fault stored
  output logic                        fault_hard_q,          // power-off-only fault stored
  output logic                        fault_reset_pulse_q,   // pulse: fault cleared
  output logic [RAMP_W-1:0]           ramp_up_q,             // active acceleration time
  output logic [RAMP_W-1:0]           ramp_down_q,           // active deceleration time
  output logic                        do_sink_q              // high: open collector pulls low
);

  // pick one synchronised input by index
  function automatic logic pick(input logic [3:0] v, input logic [1:0] idx);
    pick = v[idx];
  endfunction : pick

  // pwm high while qty*100/(full*pct) > cnt/period, kept in products to avoid a divider
  function automatic logic ratio_on(input logic [47:0] qty, input logic [47:0] full,
                                    input logic [47:0] pct, input logic [47:0] cnt);
    ratio_on = (qty * 48'(`DCL_PCT_DEN) * 48'(PWM_PERIOD_CYC)) > (cnt * full * pct);
  endfunction : ratio_on

  logic [3:0]       sync1_q, sync2_q, sync3_q;  // three-stage pin synchroniser
  logic [3:0]       in_q;                       // accepted level, second and third agree
  logic [3:0]       in_valid_q;                 // fill marks; top bit once in_q is real
  logic [3:0]       prev_q;                     // previous accepted level
  logic             prev_valid_q;               // previous sample is real
  logic [3:0]       rise, fall;                 // one-cycle edge events
  logic             fwd_lvl, rev_lvl, stop_lvl; // function levels
  logic             fwd_rise, rev_rise, stop_fall, frst_rise;
  logic             armed_q;                    // three-wire rearm after release
  logic             run_fwd_d, run_rev_d;
  logic [1:0]       preset_sel;
  logic [16:0]      pwm_cnt_q;                  // pwm period counter
  logic             is_3w;

  // pin synchroniser; only the second stage reads the first
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_q <= `DCL_IN_RST;
      sync2_q <= `DCL_IN_RST;
      sync3_q <= `DCL_IN_RST;
    end else begin
      sync1_q <= logic_in_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // accept a bit once stages two and three agree; this filters single-cycle glitches
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      in_q       <= `DCL_IN_RST;
      in_valid_q <= 4'h0;
    end else begin
      in_q       <= (sync2_q & sync3_q) | (in_q & (sync2_q ^ sync3_q));
      in_valid_q <= {in_valid_q[2:0], 1'b1};  // a pin needs four edges to reach in_q
    end
  end

  // previous sample for edge compare; first sample makes no edge, so a held input
  // at power-up never looks like a transition
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prev_q       <= `DCL_IN_RST;
      prev_valid_q <= 1'b0;
    end else begin
      prev_q       <= in_q;
      prev_valid_q <= in_valid_q[3];
    end
  end

  assign rise = prev_valid_q ? (in_q & ~prev_q) : 4'h0;
  assign fall = prev_valid_q ? (~in_q & prev_q) : 4'h0;

  // function map: every function indexes the same samples, so shared inputs act together
  assign is_3w     = (control_type_select == dcl_pkg::dcl_three_wire_code);
  assign fwd_lvl   = pick(in_q, is_3w ? `DCL_FWD_IDX_3W : `DCL_FWD_IDX_2W);
  assign fwd_rise  = pick(rise, is_3w ? `DCL_FWD_IDX_3W : `DCL_FWD_IDX_2W);
  assign rev_lvl   = reverse_assign_en & pick(in_q, reverse_assign);
  assign rev_rise  = reverse_assign_en & pick(rise, reverse_assign);
  assign stop_lvl  = pick(in_q, `DCL_STOP_IDX);
  assign stop_fall = is_3w & pick(fall, `DCL_STOP_IDX);
  assign frst_rise = fault_reset_en & pick(rise, fault_reset_idx);

  // run decision per control type
  always_comb begin
    run_fwd_d = run_fwd_q;
    run_rev_d = run_rev_q;
    if (!is_3w) begin
      case (two_wire_type)
        // level sense: both asserted is ambiguous, so neither runs
        dcl_pkg::dcl_level_sense: begin
          run_fwd_d = fwd_lvl & ~rev_lvl;
          run_rev_d = rev_lvl & ~fwd_lvl;
        end
        // transition sense: a start needs an edge, level loss stops
        dcl_pkg::dcl_transition_sense: begin
          run_fwd_d = fwd_lvl & (run_fwd_q | fwd_rise) & ~run_rev_q;
          run_rev_d = rev_lvl & (run_rev_q | rev_rise) & ~run_fwd_d;
        end
        // forward priority: levels, forward wins a tie
        dcl_pkg::dcl_forward_priority: begin
          run_fwd_d = fwd_lvl;
          run_rev_d = rev_lvl & ~fwd_lvl;
        end
        default: begin
          run_fwd_d = 1'b0;
          run_rev_d = 1'b0;
        end
      endcase
    end else if (!stop_lvl || frst_rise) begin
      // open stop input or manual fault reset drops the latch
      run_fwd_d = 1'b0;
      run_rev_d = 1'b0;
    end else if (armed_q && !run_fwd_q && !run_rev_q) begin
      // latch a run pulse until stop opens; forward wins a simultaneous pulse
      run_fwd_d = fwd_rise;
      run_rev_d = rev_rise & ~fwd_rise;
    end
  end

  // run command registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      run_fwd_q <= 1'b0;
      run_rev_q <= 1'b0;
    end else begin
      run_fwd_q <= run_fwd_d;
      run_rev_q <= run_rev_d;
    end
  end

  // three-wire rearm: cleared at power-up, fault reset and stop; set once both released
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
    end else if (!stop_lvl || frst_rise) begin
      armed_q <= 1'b0;
    end else if (!fwd_lvl && !rev_lvl && prev_valid_q) begin
      armed_q <= 1'b1;
    end
  end

  // power stage only with a run command and no soft or hard fault stored
  assign motor_enable = (run_fwd_q | run_rev_q) & ~fault_soft_q & ~fault_hard_q;

  // ramped stop request pulse on stop opening, three-wire only
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ramp_stop_q <= 1'b0;
    end else begin
      ramp_stop_q <= stop_fall;
    end
  end

  // preset selection; high select only counts with four presets
  assign preset_sel = {(preset_mode == dcl_pkg::dcl_preset_four) &
                         pick(in_q, preset_select_high),
                       (preset_mode != dcl_pkg::dcl_preset_none) &
                         pick(in_q, preset_select_low)};

  // speed reference; a preset beats the analog or pot reference
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      speed_cmd_q <= '0;
    end else begin
      case (preset_sel)
        2'h1:    speed_cmd_q <= preset_speed_second;
        2'h2:    speed_cmd_q <= preset_speed_third;
        2'h3:    speed_cmd_q <= preset_speed_fourth;
        default: speed_cmd_q <= (speed_ref < low_speed_limit) ? low_speed_limit
                                                               : speed_ref;
      endcase
    end
  end

  // resettable fault: a new fault in the reset cycle wins over the clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fault_soft_q <= 1'b0;
    end else if (fault_detect && !fault_power_only) begin
      fault_soft_q <= 1'b1;
    end else if (frst_rise && !fault_cause_present) begin
      fault_soft_q <= 1'b0;
    end
  end

  // power-off class faults ignore the reset input; only sys_rst (power-up) clears
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fault_hard_q <= 1'b0;
    end else if (fault_detect && fault_power_only) begin
      fault_hard_q <= 1'b1;
    end
  end

  // pulse when a stored fault is actually cleared
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fault_reset_pulse_q <= 1'b0;
    end else begin
      fault_reset_pulse_q <= frst_rise & fault_soft_q & ~fault_cause_present &
                             ~(fault_detect & ~fault_power_only);
    end
  end

  // ramp times follow the ramp switch input level
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ramp_up_q   <= '0;
      ramp_down_q <= '0;
    end else if (ramp_switch_en && pick(in_q, ramp_switch_input)) begin
      ramp_up_q   <= second_ramp_up_time;
      ramp_down_q <= second_ramp_down_time;
    end else begin
      ramp_up_q   <= primary_ramp_up_time;
      ramp_down_q <= primary_ramp_down_time;
    end
  end

  // free-running pwm period counter; live quantities, so duty may change mid-period
  always_ff @(posedge core_clk) begin
    if (sys_rst || pwm_cnt_q == 17'(PWM_PERIOD_CYC - 1)) begin
      pwm_cnt_q <= '0;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 17'h00001;
    end
  end

  // multi-function output; high turns the sink on, pulling the pin low to 0 V
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      do_sink_q <= 1'b0;
    end else begin
      case (out_mode)
        dcl_pkg::dcl_ao_current:
          do_sink_q <= ratio_on(48'(motor_current), 48'(nominal_current),
                                48'(`DCL_CUR_FULL_PCT), 48'(pwm_cnt_q));
        dcl_pkg::dcl_ao_frequency:
          do_sink_q <= ratio_on(48'(motor_freq), 48'(high_speed_limit),
                                48'(`DCL_FREQ_FULL_PCT), 48'(pwm_cnt_q));
        dcl_pkg::dcl_lo_freq_thresh: do_sink_q <= motor_freq > freq_threshold;
        dcl_pkg::dcl_lo_cur_thresh:  do_sink_q <= motor_current > current_threshold;
        dcl_pkg::dcl_lo_ref_reached: do_sink_q <= motor_freq == speed_cmd_q;
        default:                     do_sink_q <= 1'b0;
      endcase
    end
  end

  default clocking dcl_cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_level_run_fwd: assert property (
    (!is_3w && two_wire_type == dcl_pkg::dcl_level_sense && fwd_lvl && !rev_lvl)
      |=> run_fwd_q) else $error("level sense forward not running");
  a_fwd_priority_tie: assert property (
    (!is_3w && two_wire_type == dcl_pkg::dcl_forward_priority && fwd_lvl && rev_lvl)
      |=> (run_fwd_q && !run_rev_q)) else $error("forward did not win tie");
  a_trans_no_start: assert property (
    (!is_3w && two_wire_type == dcl_pkg::dcl_transition_sense && !run_fwd_q && !fwd_rise)
      |=> !run_fwd_q) else $error("transition mode started without edge");
  a_stop_opening: assert property (
    stop_fall |=> (ramp_stop_q && !run_fwd_q && !run_rev_q))
    else $error("stop opening did not stop");
  a_three_wire_hold: assert property (
    (is_3w && run_fwd_q && stop_lvl && !frst_rise) |=> run_fwd_q)
    else $error("three-wire run latch lost");
  a_rearm_needed: assert property (
    (is_3w && !armed_q && !run_fwd_q && !run_rev_q) |=> (!run_fwd_q && !run_rev_q))
    else $error("run started before release");
  a_no_reverse: assert property (
    (!reverse_assign_en && !run_rev_q) |=> !run_rev_q) else $error("reverse without assign");
  a_preset_fourth: assert property (
    (preset_sel == 2'h3) |=> (speed_cmd_q == $past(preset_speed_fourth)))
    else $error("fourth preset not selected");
  a_hard_fault_kept: assert property (
    fault_hard_q |=> fault_hard_q [*2]) else $error("power-off fault cleared");
  a_soft_fault_clear: assert property (
    (fault_soft_q && frst_rise && !fault_cause_present && !fault_detect)
      |=> (!fault_soft_q && fault_reset_pulse_q)) else $error("fault reset ignored");
  a_ramp_second: assert property (
    (ramp_switch_en && pick(in_q, ramp_switch_input))
      |=> (ramp_up_q == $past(second_ramp_up_time))) else $error("second ramp not used");
  a_cur_thresh_out: assert property (
    (out_mode == dcl_pkg::dcl_lo_cur_thresh && motor_current > current_threshold)
      |=> do_sink_q) else $error("current threshold output missing");
  a_edge_one_cycle: assert property (
    rise[0] |=> !rise[0]) else $error("edge pulse longer than one cycle");

  c_three_wire_run: cover property (is_3w && !run_fwd_q ##1 run_fwd_q);
  c_fault_cleared:  cover property (fault_soft_q ##1 !fault_soft_q);
  c_pwm_high:       cover property (out_mode == dcl_pkg::dcl_ao_frequency && do_sink_q);
  c_preset_third:   cover property (preset_sel == 2'h2);

endmodule : dcl_drive_cmd

// ===== dcl_switch_model.sv
// switch model: operator switches or controller driving the four logic inputs
module dcl_switch_model (
  input  wire logic       core_clk,
  input  wire logic [3:0] sw_req,       // wanted switch states
  output logic      [3:0] logic_in_pin  // contact levels at the pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // all switches open at power-up, so no run command is present
  initial logic_in_pin = 4'h0;
  // contacts change just after an edge and then hold; bounce is not modelled,
  // so lost short pulses are not exercised here
  always @(posedge core_clk) begin
    logic_in_pin <= #1 sw_req;
  end
endmodule : dcl_switch_model

// ===== dcl_drive_cmd_bench.sv
// bench for the drive command logic: run/stop, presets, faults, ramps, output
module dcl_drive_cmd_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int P     = 100;    // short pwm period keeps the run brief
  localparam int LIMIT = 20000;  // cycle ceiling, tests take about 520
  logic core_clk = 1'b0;
  logic sys_rst  = 1'b1;
  logic [3:0] sw, logic_in_pin;
  dcl_pkg::dcl_ctrl_t     control_type_select;
  dcl_pkg::dcl_two_wire_t two_wire_type;
  dcl_pkg::dcl_preset_t   preset_mode;
  dcl_pkg::dcl_out_mode_t out_mode;
  logic reverse_assign_en, fault_reset_en, ramp_switch_en;
  logic fault_detect, fault_power_only, fault_cause_present;
  logic [1:0] reverse_assign, preset_select_low, preset_select_high;
  logic [1:0] fault_reset_idx, ramp_switch_input;
  logic [15:0] speed_ref, low_speed_limit, high_speed_limit, preset_speed_second;
  logic [15:0] preset_speed_third, preset_speed_fourth, motor_freq, motor_current;
  logic [15:0] nominal_current, freq_threshold, current_threshold, speed_cmd_q;
  logic [9:0] primary_ramp_up_time, primary_ramp_down_time, second_ramp_up_time;
  logic [9:0] second_ramp_down_time, ramp_up_q, ramp_down_q;
  logic run_fwd_q, run_rev_q, motor_enable, ramp_stop_q, fault_soft_q;
  logic fault_hard_q, fault_reset_pulse_q, do_sink_q;
  int err_total = 0;
  int n_tests   = 0;
  int cyc       = 0;
  // free-running core clock
  always #2.5 core_clk = ~core_clk;
  dcl_switch_model dcl_switch_model_inst (.core_clk, .sw_req(sw), .logic_in_pin);
  dcl_drive_cmd #(.PWM_PERIOD_CYC(P)) dcl_drive_cmd_inst (
    .core_clk, .sys_rst, .logic_in_pin, .control_type_select, .two_wire_type,
    .reverse_assign_en, .reverse_assign, .preset_mode, .preset_select_low,
    .preset_select_high, .fault_reset_en, .fault_reset_idx, .ramp_switch_en,
    .ramp_switch_input, .speed_ref, .low_speed_limit, .high_speed_limit,
    .preset_speed_second, .preset_speed_third, .preset_speed_fourth,
    .primary_ramp_up_time, .primary_ramp_down_time, .second_ramp_up_time,
    .second_ramp_down_time, .fault_detect, .fault_power_only, .fault_cause_present,
    .motor_freq, .motor_current, .nominal_current, .freq_threshold,
    .current_threshold, .out_mode, .run_fwd_q, .run_rev_q, .motor_enable,
    .ramp_stop_q, .speed_cmd_q, .fault_soft_q, .fault_hard_q, .fault_reset_pulse_q,
    .ramp_up_q, .ramp_down_q, .do_sink_q
  );
  // wait n edges, then settle 1 ns past the edge
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  // set switches and wait out the sync pipeline plus the answer edge
  task automatic pins(input logic [3:0] v);
    sw = v;
    step(8);
  endtask : pins
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  // count cycles a pulse or the sink is high: 0 stop, 1 fault clear, 2 sink
  task automatic cnt(input int k, input int n, output int c);
    c = 0;
    repeat (n) begin
      step(1);
      c += (k == 0) ? ramp_stop_q : (k == 1) ? fault_reset_pulse_q : do_sink_q;
    end
  endtask : cnt
  task automatic do_reset();
    sys_rst = 1'b1;
    step(8);
    sys_rst = 1'b0;
  endtask : do_reset
  task automatic report_and_stop();
    if (err_total == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  // two-wire level and forward-priority, reverse on input three
  task automatic t_two_wire();
    pins(4'h1);
    chk("fwd", {run_fwd_q, motor_enable}, 2'h3);
    pins(4'h4);
    chk("rev", {run_fwd_q, run_rev_q}, 2'h1);
    pins(4'h5);
    chk("both level", {run_fwd_q, run_rev_q}, 2'h0);
    two_wire_type = dcl_pkg::dcl_forward_priority;
    step(8);
    chk("both prio", {run_fwd_q, run_rev_q}, 2'h2);
    reverse_assign_en = 1'b0;
    pins(4'h4);
    chk("no rev", {run_fwd_q, run_rev_q}, 2'h0);
    reverse_assign_en = 1'b1;
    two_wire_type = dcl_pkg::dcl_level_sense;
    pins(4'h0);
    chk("stop", motor_enable, 1'b0);
  endtask : t_two_wire
  // run input held through reset must not start the motor
  task automatic t_transition();
    two_wire_type = dcl_pkg::dcl_transition_sense;
    sw = 4'h1;
    do_reset();
    step(10);
    chk("held no start", run_fwd_q, 1'b0);
    pins(4'h0);
    pins(4'h1);
    chk("edge start", run_fwd_q, 1'b1);
    pins(4'h0);
    two_wire_type = dcl_pkg::dcl_level_sense;
  endtask : t_transition
  // three-wire: latch, ramped stop, rearm only after release
  task automatic t_three_wire();
    int c;
    control_type_select = dcl_pkg::dcl_three_wire_code;
    pins(4'h1);
    pins(4'h3);
    pins(4'h1);
    chk("latched", run_fwd_q, 1'b1);
    sw = 4'h0;
    cnt(0, 10, c);
    chk("ramp stop", c, 1);
    chk("stopped", run_fwd_q, 1'b0);
    pins(4'h5);
    pins(4'h7);
    chk("not armed", motor_enable, 1'b0);
    pins(4'h1);
    pins(4'h5);
    chk("rev run", run_rev_q, 1'b1);
    pins(4'h0);
    control_type_select = dcl_pkg::dcl_two_wire_code;
  endtask : t_three_wire
  // preset decode; input three also selects the second ramp
  task automatic t_presets();
    preset_mode = dcl_pkg::dcl_preset_four;
    speed_ref = 16'h0020;
    pins(4'h0);
    chk("clamp", speed_cmd_q, 16'h0032);
    chk("ramp one", ramp_up_q, 10'h00A);
    pins(4'h4);
    chk("second", speed_cmd_q, 16'h0064);
    chk("ramp two up", ramp_up_q, 10'h01E);
    chk("ramp two dn", ramp_down_q, 10'h028);
    pins(4'h8);
    chk("third", speed_cmd_q, 16'h0096);
    pins(4'hC);
    chk("fourth", speed_cmd_q, 16'h00C8);
    preset_mode = dcl_pkg::dcl_preset_two;
    pins(4'h8);
    chk("two low", speed_cmd_q, 16'h0032);
    pins(4'h4);
    chk("two high", speed_cmd_q, 16'h0064);
    preset_mode = dcl_pkg::dcl_preset_none;
    speed_ref = 16'h012C;
    pins(4'h0);
  endtask : t_presets
  // resettable fault cleared on a rising edge, power-off class kept
  task automatic t_faults();
    int c;
    pins(4'h1);
    fault_detect = 1'b1;
    step(1);
    fault_detect = 1'b0;
    step(1);
    chk("soft set", {fault_soft_q, motor_enable}, 2'h2);
    fault_cause_present = 1'b1;
    pins(4'h9);
    chk("cause kept", fault_soft_q, 1'b1);
    pins(4'h1);
    fault_cause_present = 1'b0;
    sw = 4'h9;
    cnt(1, 10, c);
    chk("reset pulse", c, 1);
    chk("soft clear", {fault_soft_q, motor_enable}, 2'h1);
    pins(4'h1);
    fault_power_only = 1'b1;
    fault_detect = 1'b1;
    step(1);
    fault_detect = 1'b0;
    fault_power_only = 1'b0;
    pins(4'h9);
    chk("hard kept", {fault_hard_q, motor_enable}, 2'h2);
    do_reset();
    step(2);
    chk("hard power off", fault_hard_q, 1'b0);
    pins(4'h0);
  endtask : t_faults
  // pwm duty in both analog modes, then the switch modes
  task automatic t_output();
    int c;
    motor_current = 16'h00C8;
    step(3);
    cnt(2, P, c);
    chk("cur duty", c, 50);
    out_mode = dcl_pkg::dcl_ao_frequency;
    motor_freq = 16'h0064;
    step(3);
    cnt(2, P, c);
    chk("freq duty", c, 25);
    out_mode = dcl_pkg::dcl_lo_cur_thresh;
    step(3);
    chk("cur above", do_sink_q, 1'b1);
    motor_current = 16'h0064;
    step(3);
    chk("cur at thr", do_sink_q, 1'b0);
    out_mode = dcl_pkg::dcl_lo_freq_thresh;
    motor_freq = 16'h012C;
    step(3);
    chk("freq above", do_sink_q, 1'b1);
    out_mode = dcl_pkg::dcl_lo_ref_reached;
    step(3);
    chk("ref reached", do_sink_q, 1'b1);
    motor_freq = 16'h012D;
    step(3);
    chk("ref missed", do_sink_q, 1'b0);
  endtask : t_output
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      report_and_stop();
    end
  end
  // defaults, reset, then each scenario in turn
  initial begin
    sw = 4'h0;
    control_type_select = dcl_pkg::dcl_two_wire_code;
    two_wire_type = dcl_pkg::dcl_level_sense;
    preset_mode = dcl_pkg::dcl_preset_none;
    out_mode = dcl_pkg::dcl_ao_current;
    {reverse_assign_en, fault_reset_en, ramp_switch_en} = 3'h7;
    {fault_detect, fault_power_only, fault_cause_present} = 3'h0;
    reverse_assign = 2'h2;
    preset_select_low = 2'h2;
    preset_select_high = 2'h3;
    fault_reset_idx = 2'h3;
    ramp_switch_input = 2'h2;
    speed_ref = 16'h012C;
    low_speed_limit = 16'h0032;
    high_speed_limit = 16'h0190;
    preset_speed_second = 16'h0064;
    preset_speed_third = 16'h0096;
    preset_speed_fourth = 16'h00C8;
    primary_ramp_up_time = 10'h00A;
    primary_ramp_down_time = 10'h014;
    second_ramp_up_time = 10'h01E;
    second_ramp_down_time = 10'h028;
    {motor_freq, motor_current} = 32'h0;
    nominal_current = 16'h00C8;
    freq_threshold = 16'h00FA;
    current_threshold = 16'h0064;
    do_reset();
    chk("reset", {run_fwd_q, fault_soft_q, do_sink_q}, 3'h0);
    t_two_wire();
    t_transition();
    t_three_wire();
    t_presets();
    t_faults();
    t_output();
    report_and_stop();
  end
endmodule : dcl_drive_cmd_bench
